// ### dsd_pkg.sv
// package: constants and types for the dual element simd datapath
package dsd_pkg;
  localparam int DW = 40;
  localparam int AW = 4;
  localparam int NREG = 16;
  localparam int BUSW = 64;
  localparam int NUNI = 4;
  localparam int TMW = 32;
  // core mode word bit positions
  localparam int MODE_SEC_ENABLE_BIT = 0;
  localparam int MODE_ALT_DATA_BIT = 1;
  localparam int MODE_ALT_ADDR_BIT = 2;
  localparam int MODE_ALT_MRES_BIT = 3;
  localparam int MODE_TIMER_FLAG_BIT = 4;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [DW-1:0] REG_RESET = 40'h00_0000_0000;
  localparam logic [TMW-1:0] TIMER_RESET = 32'h0000_0000;
  // operand format codes
  localparam logic [1:0] FMT_FIXED32 = 2'h0;
  localparam logic [1:0] FMT_FLOAT32 = 2'h1;
  localparam logic [1:0] FMT_FLOAT40 = 2'h2;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ADD = 4'h1, OP_SUB = 4'h2, OP_AND = 4'h3,
    OP_OR = 4'h4, OP_XOR = 4'h5, OP_MUL = 4'h6, OP_SHL = 4'h7,
    OP_SHR = 4'h8, OP_MULADD = 4'h9, OP_PASS = 4'ha
  } dsd_op_e;
  typedef enum logic [2:0] {
    BIT_SET = 3'h0, BIT_CLR = 3'h1, BIT_TGL = 3'h2, BIT_TST = 3'h3, BIT_XOR = 3'h4
  } dsd_bitop_e;
endpackage

// ### dsd_pe_if.sv
// interface: one instruction slot as seen by a processing element
`timescale 1ns/1ps
interface dsd_pe_if;
  import dsd_pkg::*;
  logic we;
  logic alt;
  dsd_op_e op;
  logic [1:0] fmt;
  logic [AW-1:0] ra;
  logic [AW-1:0] rb;
  logic [AW-1:0] rd;
  logic [AW-1:0] rm;
  logic ld_en;
  logic [AW-1:0] ld_addr;
  logic [DW-1:0] ld_data;
  logic [AW-1:0] st_addr;
  logic [DW-1:0] st_data;
  logic [DW-1:0] result;
  modport core (output we, alt, op, fmt, ra, rb, rd, rm, ld_en, ld_addr, ld_data, st_addr,
                input st_data, result);
  modport pe (input we, alt, op, fmt, ra, rb, rd, rm, ld_en, ld_addr, ld_data, st_addr,
              output st_data, result);
endinterface

// ### dsd_pe.sv
// processing element: register file with two banks and single cycle compute units
`timescale 1ns/1ps
module dsd_pe
  import dsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  dsd_pe_if.pe pe_if
);
  logic [DW-1:0] rf [2*NREG]; // [RL8]
  logic [DW-1:0] mres [2];
  logic [DW-1:0] opa, opb, alu_r, mul_r, shf_r, res;
  logic [2*DW-1:0] prod;
  logic [AW:0] ia, ib, id, il, is;
  always_comb begin
    ia = {pe_if.alt, pe_if.ra};
    ib = {pe_if.alt, pe_if.rb};
    id = {pe_if.alt, pe_if.rd};
    il = {pe_if.alt, pe_if.ld_addr};
    is = {pe_if.alt, pe_if.st_addr};
    opa = rf[ia];
    opb = rf[ib];
    // fixed and single formats work in the upper 32 bits, low byte cleared
    if (pe_if.fmt != FMT_FLOAT40) begin
      opa[7:0] = 8'h00;
      opb[7:0] = 8'h00;
    end
    prod = opa * opb;
    mul_r = prod[2*DW-1:DW];
    alu_r = opa;
    shf_r = opa;
    unique case (pe_if.op)
      OP_ADD: alu_r = opa + opb;
      OP_SUB: alu_r = opa - opb;
      OP_AND: alu_r = opa & opb;
      OP_OR: alu_r = opa | opb;
      OP_XOR: alu_r = opa ^ opb;
      OP_SHL: shf_r = opa << opb[5:0];
      OP_SHR: shf_r = opa >> opb[5:0];
      default: ;
    endcase
    // multifunction: alu and multiplier in the same cycle [RL6]
    unique case (pe_if.op)
      OP_MUL: res = mul_r;
      OP_SHL, OP_SHR: res = shf_r;
      OP_MULADD: res = alu_r;
      default: res = alu_r;
    endcase
    pe_if.result = res;
    pe_if.st_data = rf[is];
  end
  // all units settle inside one cycle, result written at the next edge [RL5]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 2*NREG; i++) begin
        rf[i] <= REG_RESET;
      end
      mres[0] <= REG_RESET;
      mres[1] <= REG_RESET;
    end else begin
      if (pe_if.we && pe_if.op != OP_NOP) begin
        rf[id] <= res;
      end
      if (pe_if.we && pe_if.op == OP_MULADD) begin
        rf[{pe_if.alt, pe_if.rm}] <= mul_r; // [RL6]
      end
      if (pe_if.we && (pe_if.op == OP_MUL || pe_if.op == OP_MULADD)) begin
        mres[pe_if.alt] <= mul_r; // [RL9]
      end
      // loads run beside instructions, so they land with no instruction issued
      if (pe_if.ld_en) begin
        rf[il] <= pe_if.ld_data;
      end
    end
  end
endmodule

// ### dsd_core.sv
// top: dual element simd datapath with universal, exchange and timer logic
// Overview of operation
// (RL1) first element always runs; second only when its mode enable bit is set
// (RL2) with second enabled, each instruction runs in both elements on own data
// (RL3) dual mode doubles memory data width so both elements are fed
// (RL4) in dual mode every generator access moves a pair of values
// (RL5) alu, multiplier and shifter each finish within one clock
// (RL6) multifunction starts alu and multiply together, in both elements when dual
// (RL7) formats: 32-bit single float, 40-bit extended float, 32-bit fixed
// (RL8) each element has sixteen primary plus sixteen alternate data registers
// (RL9) data, address and multiplier result registers have alternate copies; no address registers here, mres bank follows MODE_ALT_DATA_BIT
// (RL10) primary banks active after reset; alternates selected by mode bits
// (RL11) four universal registers offer set, clear, toggle, test, xor
// (RL12) exchange register moves values between buses and register file; here it takes bus or register words and drives only the program bus
// (RL13) program and data buses carry two 64-bit transfers each cycle
// (RL14) core timer raises periodic interrupts and optionally drives a flag
// (RL15) disabled second element keeps its registers untouched
`timescale 1ns/1ps
module dsd_core
  import dsd_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic INSN_VALID_I,
  input wire dsd_pkg::dsd_op_e OP_I,
  input wire logic [1:0] FMT_I,
  input wire logic [dsd_pkg::AW-1:0] RA_I,
  input wire logic [dsd_pkg::AW-1:0] RB_I,
  input wire logic [dsd_pkg::AW-1:0] RD_I,
  input wire logic [dsd_pkg::AW-1:0] RM_I,
  input wire logic MODE_WE_I,
  input wire logic [31:0] MODE_WDATA_I,
  input wire logic LOAD_I,
  input wire logic [dsd_pkg::AW-1:0] LOAD_ADDR_I,
  input wire logic [dsd_pkg::BUSW-1:0] DM_RDATA_I,
  input wire logic [dsd_pkg::AW-1:0] STORE_ADDR_I,
  input wire logic [dsd_pkg::BUSW-1:0] PM_RDATA_I,
  input wire logic [1:0] UNI_SEL_I,
  input wire logic UNI_WE_I,
  input wire logic [31:0] UNI_WDATA_I,
  input wire logic UNI_OP_VALID_I,
  input wire dsd_pkg::dsd_bitop_e UNI_OP_I,
  input wire logic [31:0] UNI_MASK_I,
  input wire logic [1:0] EXCH_CMD_I,
  input wire logic TIMER_WE_I,
  input wire logic [dsd_pkg::TMW-1:0] TIMER_PERIOD_I,
  output logic [31:0] MODE_O,
  output logic [dsd_pkg::DW-1:0] PRI_RESULT_O,
  output logic [dsd_pkg::DW-1:0] SEC_RESULT_O,
  output logic [dsd_pkg::BUSW-1:0] DM_WDATA_O,
  output logic [dsd_pkg::BUSW-1:0] PM_WDATA_O,
  output logic [31:0] UNI_RDATA_O,
  output logic UNI_TEST_O,
  output logic TIMER_IRQ_O,
  output logic TIMER_FLAG_O
);
  import dsd_pkg::*;
  dsd_pe_if pri_if ();
  dsd_pe_if sec_if ();
  logic [31:0] core_mode_word, next_mode;
  logic [31:0] universal_bit_reg [NUNI];
  logic [31:0] next_uni [NUNI];
  logic [BUSW-1:0] bus_exchange_reg, next_exch;
  logic [TMW-1:0] period, next_period, tcount, next_tcount;
  logic irq, next_irq, flag, next_flag, utest, next_utest;
  logic [31:0] uni_rd, next_uni_rd;
  logic [DW-1:0] pri_res, next_pri_res, sec_res, next_sec_res;
  logic [BUSW-1:0] dm_w, next_dm_w, pm_w, next_pm_w;
  logic second_element_enable;
  logic [31:0] target;

  assign second_element_enable = core_mode_word[MODE_SEC_ENABLE_BIT];

  // both elements see the same instruction fields [RL2]
  always_comb begin
    pri_if.we = INSN_VALID_I; // [RL1]
    sec_if.we = INSN_VALID_I && second_element_enable; // [RL15]
    pri_if.alt = core_mode_word[MODE_ALT_DATA_BIT]; // [RL10]
    sec_if.alt = core_mode_word[MODE_ALT_DATA_BIT];
    pri_if.op = OP_I;
    sec_if.op = OP_I;
    pri_if.fmt = FMT_I; // [RL7]
    sec_if.fmt = FMT_I;
    pri_if.ra = RA_I;
    sec_if.ra = RA_I;
    pri_if.rb = RB_I;
    sec_if.rb = RB_I;
    pri_if.rd = RD_I;
    sec_if.rd = RD_I;
    pri_if.rm = RM_I;
    sec_if.rm = RM_I;
    pri_if.ld_en = LOAD_I;
    // a disabled second element must not see loads either [RL15]
    sec_if.ld_en = LOAD_I && second_element_enable;
    pri_if.ld_addr = LOAD_ADDR_I;
    sec_if.ld_addr = LOAD_ADDR_I;
    pri_if.st_addr = STORE_ADDR_I;
    sec_if.st_addr = STORE_ADDR_I;
    // low 32 bits feed the first element, high 32 bits the second [RL3] [RL4]
    pri_if.ld_data = {DM_RDATA_I[31:0], 8'h00};
    sec_if.ld_data = {DM_RDATA_I[63:32], 8'h00};
  end

  dsd_pe u_pri (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .pe_if(pri_if)
  );
  dsd_pe u_sec (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .pe_if(sec_if)
  );

  always_comb begin
    next_mode = MODE_WE_I ? MODE_WDATA_I : core_mode_word;
    next_pri_res = INSN_VALID_I ? pri_if.result : pri_res;
    next_sec_res = (INSN_VALID_I && second_element_enable) ? sec_if.result : sec_res;
    // store: pair of values in dual mode, single value otherwise [RL4] [RL13]
    if (second_element_enable) begin
      next_dm_w = {sec_if.st_data[DW-1:8], pri_if.st_data[DW-1:8]};
    end else begin
      next_dm_w = {32'h0000_0000, pri_if.st_data[DW-1:8]};
    end
    next_exch = bus_exchange_reg;
    unique case (EXCH_CMD_I)
      2'h1: next_exch = PM_RDATA_I; // [RL12]
      2'h2: next_exch = DM_RDATA_I; // [RL12]
      // 40-bit register widened into the 64-bit exchange word [RL12]
      2'h3: next_exch = {24'h00_0000, pri_if.st_data};
      default: ;
    endcase
    next_pm_w = bus_exchange_reg;
  end

  // universal registers: bit operations on a selected word [RL11]
  always_comb begin
    next_utest = utest;
    target = universal_bit_reg[UNI_SEL_I];
    for (int i = 0; i < NUNI; i++) begin
      next_uni[i] = universal_bit_reg[i];
    end
    if (UNI_WE_I) begin
      next_uni[UNI_SEL_I] = UNI_WDATA_I;
    end else if (UNI_OP_VALID_I) begin
      unique case (UNI_OP_I)
        BIT_SET: next_uni[UNI_SEL_I] = target | UNI_MASK_I;
        BIT_CLR: next_uni[UNI_SEL_I] = target & ~UNI_MASK_I;
        BIT_TGL, BIT_XOR: next_uni[UNI_SEL_I] = target ^ UNI_MASK_I;
        BIT_TST: next_utest = ((target & UNI_MASK_I) == UNI_MASK_I);
        default: ;
      endcase
    end
    // read port registered from the updated word, so it shows the new value next cycle
    next_uni_rd = next_uni[UNI_SEL_I];
  end

  // periodic timer; period zero keeps it idle [RL14]
  always_comb begin
    next_period = TIMER_WE_I ? TIMER_PERIOD_I : period;
    next_tcount = tcount;
    next_irq = 1'b0;
    next_flag = 1'b0;
    if (TIMER_WE_I) begin
      next_tcount = TIMER_PERIOD_I;
    end else if (period != TIMER_RESET) begin
      if (tcount <= 32'h0000_0001) begin
        next_tcount = period;
        next_irq = 1'b1;
        next_flag = core_mode_word[MODE_TIMER_FLAG_BIT];
      end else begin
        next_tcount = tcount - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RSTN_I) begin
      core_mode_word <= MODE_RESET; // [RL10]
      for (int i = 0; i < NUNI; i++) begin
        universal_bit_reg[i] <= 32'h0000_0000;
      end
      bus_exchange_reg <= 64'h0000_0000_0000_0000;
      period <= TIMER_RESET;
      tcount <= TIMER_RESET;
      irq <= 1'b0;
      flag <= 1'b0;
      utest <= 1'b0;
      uni_rd <= 32'h0000_0000;
      pri_res <= REG_RESET;
      sec_res <= REG_RESET;
      dm_w <= 64'h0000_0000_0000_0000;
      pm_w <= 64'h0000_0000_0000_0000;
    end else begin
      core_mode_word <= next_mode;
      universal_bit_reg <= next_uni;
      bus_exchange_reg <= next_exch;
      period <= next_period;
      tcount <= next_tcount;
      irq <= next_irq;
      flag <= next_flag;
      utest <= next_utest;
      uni_rd <= next_uni_rd;
      pri_res <= next_pri_res;
      sec_res <= next_sec_res;
      dm_w <= next_dm_w;
      pm_w <= next_pm_w;
    end
  end

  assign MODE_O = core_mode_word;
  assign PRI_RESULT_O = pri_res;
  assign SEC_RESULT_O = sec_res;
  assign DM_WDATA_O = dm_w;
  assign PM_WDATA_O = pm_w;
  assign UNI_RDATA_O = uni_rd;
  assign UNI_TEST_O = utest;
  assign TIMER_IRQ_O = irq;
  assign TIMER_FLAG_O = flag;

  property p_sec_hold;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      (INSN_VALID_I && !second_element_enable) |=> (sec_res == $past(sec_res));
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("second result changed while off"); // [RL15]
  property p_pri_runs;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      INSN_VALID_I |=> (pri_res == $past(pri_if.result));
  endproperty
  a_pri_runs: assert property (p_pri_runs) else $error("first element result not taken"); // [RL1]
  property p_sec_runs;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      (INSN_VALID_I && second_element_enable) |=> (sec_res == $past(sec_if.result));
  endproperty
  a_sec_runs: assert property (p_sec_runs) else $error("second element result not taken"); // [RL2]
  property p_pair;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      second_element_enable |=> (dm_w[63:32] == $past(sec_if.st_data[DW-1:8]));
  endproperty
  a_pair: assert property (p_pair) else $error("store pair upper half wrong"); // [RL4]
  property p_single;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      !second_element_enable |=> (dm_w[63:32] == 32'h0000_0000);
  endproperty
  a_single: assert property (p_single) else $error("single mode upper half not zero"); // [RL3]
  property p_timer;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      irq |-> (tcount == period);
  endproperty
  a_timer: assert property (p_timer) else $error("timer did not reload on expiry"); // [RL14]
  property p_flag;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      flag |-> irq;
  endproperty
  a_flag: assert property (p_flag) else $error("flag without timer expiry"); // [RL14]
  property p_exch;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      (EXCH_CMD_I == 2'h1) |=> ##1 (pm_w == $past(PM_RDATA_I, 2));
  endproperty
  a_exch: assert property (p_exch) else $error("exchange value not passed"); // [RL12]
  property p_uset;
    @(posedge MCLK_I) disable iff (!RSTN_I)
      (!UNI_WE_I && UNI_OP_VALID_I && UNI_OP_I == BIT_SET) |=>
        ((universal_bit_reg[$past(UNI_SEL_I)] & $past(UNI_MASK_I)) == $past(UNI_MASK_I));
  endproperty
  a_uset: assert property (p_uset) else $error("universal set lost bits"); // [RL11]
endmodule

// ### dsd_mem_model.sv
// partner: data and program memory buses seen from the core side
`timescale 1ns/1ps
module dsd_mem_model (
  input wire logic clk_i,
  input wire logic dm_v_i,
  input wire logic [63:0] dm_w_i,
  input wire logic pm_v_i,
  input wire logic [63:0] pm_w_i,
  output logic [63:0] dm_rdata_o,
  output logic [63:0] pm_rdata_o
);
  logic [63:0] dm_last = 64'h0;
  logic [63:0] pm_last = 64'h0;
  always @(posedge clk_i) begin
    if (dm_v_i) dm_last <= dm_w_i;
    if (pm_v_i) pm_last <= pm_w_i;
  end
  // both buses can carry a full word in the same cycle
  // a released bus shows the inverse of its last word, never a stale copy
  assign dm_rdata_o = dm_v_i ? dm_w_i : ~dm_last;
  assign pm_rdata_o = pm_v_i ? pm_w_i : ~pm_last;
endmodule

// ### dsd_core_tb.sv
// testbench: datapath against shadow registers, queued expectations
`timescale 1ns/1ps
module dsd_core_tb;
  import dsd_pkg::*;
  typedef struct {int unsigned due; int kind; logic [63:0] exp;} dsd_note_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] ctl = 8'h00;
  dsd_op_e op = OP_NOP;
  dsd_bitop_e uop = BIT_SET;
  logic [1:0] fmt = FMT_FIXED32;
  logic [3:0] ra = 4'h0, rb = 4'h0, rd = 4'h0, la = 4'h0, sa = 4'h0;
  logic [1:0] usel = 2'h0, xcmd = 2'h0;
  logic [31:0] mdat = 32'h0, udat = 32'h0, umask = 32'h0, tper = 32'h0;
  logic [63:0] dmw = 64'h0, pmw = 64'h0, dmr, pmr, dmo, pmo;
  logic [31:0] mode_o, urd, mprev = 32'h0, sl = 32'h0, ep;
  logic [39:0] pres, sres;
  logic utst, irq, flg, sec_en = 1'b0, bank = 1'b0;
  logic [31:0] ps[2][16], ss[2][16], u[4];
  dsd_op_e ops[5] = '{OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR};
  dsd_note_s notes[$];
  int unsigned cyc = 0, last_irq = 0, irq_cnt = 0, failures = 0, compares = 0;

  always #4 clk = ~clk;

  dsd_mem_model i_mem (.clk_i(clk), .dm_v_i(ctl[6]), .dm_w_i(dmw), .pm_v_i(ctl[7]),
    .pm_w_i(pmw), .dm_rdata_o(dmr), .pm_rdata_o(pmr));
  dsd_core i_dut (.MCLK_I(clk), .RSTN_I(rstn), .INSN_VALID_I(ctl[0]), .OP_I(op), .FMT_I(fmt),
    .RA_I(ra), .RB_I(rb), .RD_I(rd), .RM_I(4'h0), .MODE_WE_I(ctl[2]), .MODE_WDATA_I(mdat),
    .LOAD_I(ctl[1]), .LOAD_ADDR_I(la), .DM_RDATA_I(dmr), .STORE_ADDR_I(sa), .PM_RDATA_I(pmr),
    .UNI_SEL_I(usel), .UNI_WE_I(ctl[3]), .UNI_WDATA_I(udat), .UNI_OP_VALID_I(ctl[4]),
    .UNI_OP_I(uop), .UNI_MASK_I(umask), .EXCH_CMD_I(xcmd), .TIMER_WE_I(ctl[5]),
    .TIMER_PERIOD_I(tper), .MODE_O(mode_o), .PRI_RESULT_O(pres), .SEC_RESULT_O(sres),
    .DM_WDATA_O(dmo), .PM_WDATA_O(pmo), .UNI_RDATA_O(urd), .UNI_TEST_O(utst),
    .TIMER_IRQ_O(irq), .TIMER_FLAG_O(flg));

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // outputs are read before the edge's own updates land
  always @(posedge clk) begin
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due == cyc) begin
        case (notes[i].kind)
          0: check("pri_result", {24'h0, pres}, notes[i].exp);
          1: check("sec_result", {24'h0, sres}, notes[i].exp);
          2: check("dm_wdata", dmo, notes[i].exp);
          3: check("pm_wdata", pmo, notes[i].exp);
          4: check("uni_rdata", {32'h0, urd}, notes[i].exp);
          5: check("uni_test", {63'h0, utst}, notes[i].exp);
          default: check("mode", {32'h0, mode_o}, notes[i].exp);
        endcase
        notes.delete(i);
      end
    end
    if (rstn) begin
      check("timer_flag", {63'h0, flg}, {63'h0, irq & mprev[MODE_TIMER_FLAG_BIT]});
      if (irq === 1'b1) begin
        if (last_irq != 0) check("irq_gap", 64'(cyc - last_irq), 64'(tper));
        irq_cnt++;
        last_irq = cyc;
      end
    end
    mprev = mode_o;
    cyc++;
  end

  function automatic logic [31:0] fn(input dsd_op_e o, input logic [31:0] a, b);
    case (o)
      OP_ADD: return a + b;
      OP_SUB: return a - b;
      OP_AND: return a & b;
      OP_OR: return a | b;
      default: return a ^ b;
    endcase
  endfunction

  task automatic step(input logic [7:0] c, input logic [1:0] x = 2'h0);
    @(negedge clk);
    ctl = c;
    xcmd = x;
  endtask

  task automatic note(input int k, input logic [63:0] e, input int d = 1);
    notes.push_back('{cyc + d, k, e});
  endtask

  task automatic setmode(input logic [31:0] v);
    step(8'h04);
    mdat = v;
    note(6, {32'h0, v});
    sec_en = v[MODE_SEC_ENABLE_BIT];
    bank = v[MODE_ALT_DATA_BIT];
  endtask

  task automatic load(input int a);
    step(8'h42);
    la = 4'(a);
    dmw = {$urandom, $urandom};
    ps[bank][a] = dmw[31:0];
    if (sec_en) ss[bank][a] = dmw[63:32];
  endtask

  task automatic store(input int a);
    step(8'h00);
    sa = 4'(a);
    note(2, {ss[bank][a], ps[bank][a]});
  endtask

  task automatic alu();
    step(8'h01);
    op = ops[$urandom % 5];
    rd = 4'($urandom);
    ra = 4'($urandom);
    rb = 4'($urandom);
    ep = fn(op, ps[bank][ra], ps[bank][rb]);
    note(0, {24'h0, ep, 8'h00});
    if (sec_en) begin
      sl = fn(op, ss[bank][ra], ss[bank][rb]);
      ss[bank][rd] = sl;
    end
    note(1, {24'h0, sl, 8'h00});
    ps[bank][rd] = ep;
  endtask

  task automatic uni(input int s, input int k);
    step(k < 0 ? 8'h08 : 8'h10);
    usel = 2'(s);
    uop = dsd_bitop_e'(k < 0 ? 0 : k);
    udat = $urandom;
    // odd words test a mask that is surely set, even words a random one
    umask = (k == 3 && s[0]) ? (u[s] & $urandom) : $urandom;
    case (k)
      -1: u[s] = udat;
      0: u[s] = u[s] | umask;
      1: u[s] = u[s] & ~umask;
      3: note(5, {63'h0, (u[s] & umask) == umask});
      default: u[s] = u[s] ^ umask;
    endcase
    note(4, {32'h0, u[s]});
  endtask

  initial begin
    ps = '{default: '{default: 32'h0}};
    ss = '{default: '{default: 32'h0}};
    void'($urandom(32'h9f2d));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    check("reset_mode", {32'h0, mode_o}, {32'h0, MODE_RESET});
    for (int i = 0; i < 16; i++) load(i);
    setmode(32'h1);
    for (int i = 0; i < 16; i++) load(i);
    for (int i = 0; i < 16; i++) store(i);
    repeat (24) alu();
    // second element off: only the first may change
    setmode(32'h0);
    repeat (8) alu();
    for (int i = 0; i < 4; i++) load(i);
    setmode(32'h1);
    for (int i = 0; i < 16; i++) store(i);
    // alternate bank must hide, then restore, the primary contents
    setmode(32'h3);
    for (int i = 0; i < 4; i++) load(i);
    for (int i = 0; i < 4; i++) store(i);
    setmode(32'h1);
    for (int i = 0; i < 4; i++) store(i);
    for (int s = 0; s < 4; s++) begin
      for (int k = -1; k < 5; k++) uni(s, k);
      step(8'h00);
    end
    step(8'h80, 2'h1);
    pmw = {$urandom, $urandom};
    note(3, pmw, 2);
    step(8'h00);
    step(8'h40, 2'h2);
    dmw = {$urandom, $urandom};
    note(3, dmw, 2);
    repeat (2) step(8'h00);
    // register file word widened onto the program bus
    step(8'h00, 2'h3);
    sa = 4'h5;
    note(3, {24'h0, ps[bank][5], 8'h00}, 2);
    repeat (2) step(8'h00);
    setmode(32'h11);
    step(8'h20);
    tper = 32'h5;
    repeat (40) step(8'h00);
    setmode(32'h1);
    repeat (12) step(8'h00);
    check("irq_count", 64'(irq_cnt >= 9), 64'h1);
    wrap_up();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule
